// >>> hw/ifvm_pkg.sv
// Purpose: Shared constants, types and helpers of the interrupt flag and
//          vector map block.
// Assumes: APB byte address of a register is four times its index.
// Notes:   Flags are numbered 1 to 21, bit n of a vector is source n.

package ifvm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NSRC = 21;
  localparam int APB_AW = 18;
  localparam int EVT_W = 3;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [15:0] IDX_PEND_LOW = 16'hFE04;
  localparam logic [15:0] IDX_PEND_MID = 16'hFE05;
  localparam logic [15:0] IDX_PEND_HIGH = 16'hFE06;
  localparam logic [15:0] IDX_EVT_STAT = 16'hFE10;
  localparam logic [15:0] IDX_EVT_MASK = 16'hFE11;
  localparam logic [15:0] IDX_SRC_EN = 16'hFE12;
  localparam logic [15:0] IDX_LAST_VEC = 16'hFE13;

  // ****************************************
  // Event bits and reset values
  // ****************************************
  localparam int EVT_NEW = 0;
  localparam int EVT_FETCH = 1;
  localparam int EVT_EMPTY = 2;
  localparam logic [EVT_W-1:0] EVT_STAT_RST = 3'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;
  localparam logic [NSRC:1] SRC_EN_RST = 21'h1FFFFF;
  localparam logic [NSRC:1] PEND_RST = 21'h000000;

  // ****************************************
  // Vector table
  // ****************************************
  localparam logic [15:0] VEC_BASE = 16'hFFD0;
  localparam logic [4:0] VEC_SLOTS = 5'h16;

  // Vector fetch sequencer states
  typedef enum logic [1:0] {
    VF_IDLE = 2'b01,
    VF_ACK = 2'b10
  } ifvm_vf_t;

  // Byte address of a register index
  function automatic logic [APB_AW-1:0] ifvm_byte_addr(logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  // High-byte location of source n; lower number sits higher
  function automatic logic [15:0] ifvm_vec_loc(logic [4:0] n);
    logic [4:0] slot;
    slot = VEC_SLOTS - n;
    return VEC_BASE + {10'h000, slot, 1'b0};
  endfunction

  // Flags of sources 1..n-1, the ones that outrank source n
  function automatic logic [NSRC:1] ifvm_above(logic [4:0] n);
    logic [NSRC:1] m;
    m = '0;
    for (int i = 1; i <= NSRC; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

endpackage

// >>> hw/ifvm_flag_if.sv
// Purpose: Carries pending flags and arbitration result between the
//          flag bank, the arbiter and the top.
// Assumes: One clock domain.
// Notes:   No logic inside.

`timescale 1ns/1ns

interface ifvm_flag_if;
  logic [ifvm_pkg::NSRC:1] pend;
  logic [ifvm_pkg::NSRC:1] rise;
  logic [ifvm_pkg::NSRC:1] en;
  logic win_vld;
  logic [4:0] win_num;

  modport bank (output pend, output rise);
  modport arb (input pend, input en, output win_vld, output win_num);
  modport core (input pend, input rise, input win_vld, input win_num,
                output en);
endinterface

// >>> hw/ifvm_flag_bank.sv
// Purpose: Captures the source request levels into pending flags.
// Assumes: Sources hold their request until serviced.
// Notes:   Rise marks a flag going from clear to set.

`timescale 1ns/1ns

module ifvm_flag_bank (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Sources
  input wire logic [ifvm_pkg::NSRC:1] src_req_i,
  // Flags out
  ifvm_flag_if.bank flags
);

  logic [ifvm_pkg::NSRC:1] pend_r;

  // Flags follow the sources one cycle late and clear at reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_r <= ifvm_pkg::PEND_RST;
    end else begin
      pend_r <= src_req_i;
    end
  end

  // Newly raised flags
  assign flags.pend = pend_r;
  assign flags.rise = src_req_i & ~pend_r;

  chk_pend_reset_zero: assert property (
    @(posedge ref_clk_i) $rose(reset_n_i) |-> pend_r == '0)
    else $error("pending flags not clear after reset");

endmodule

// >>> hw/ifvm_vec_arb.sv
// Purpose: Picks the enabled pending flag with the highest vector.
// Assumes: Flag 1 owns the top entry, flag 21 the lowest used one.
// Notes:   Purely combinational.

`timescale 1ns/1ns

module ifvm_vec_arb (
  // Clock and reset, used by checks only
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Flags in, winner out
  ifvm_flag_if.arb flags
);

  logic [ifvm_pkg::NSRC:1] cand;
  logic [4:0] num;

  assign cand = flags.pend & flags.en;

  // Scan downward so the lowest number, highest address, wins last
  always_comb begin
    num = 5'h00;
    for (int i = ifvm_pkg::NSRC; i >= 1; i--) begin
      if (cand[i]) begin
        num = 5'(i);
      end
    end
  end

  assign flags.win_vld = |cand;
  assign flags.win_num = num;

  chk_arb_top_wins: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    flags.win_vld |-> cand[flags.win_num] &&
      (cand & ifvm_pkg::ifvm_above(flags.win_num)) == '0)
    else $error("arbiter did not pick highest vector");

endmodule

// >>> hw/ifvm_top.sv
// Purpose: Interrupt flag status bytes and vector mapping with APB
//          register access and an event interrupt.
// Assumes: APB3 master, 125 MHz clock, sources are synchronous levels.
// Notes:   Status bytes are live views of the pending flags.
// Operation
// - Low status byte shows flags 6..1 in bits 7..2, bits 1..0 zero.
// - Middle status byte shows flags 14..7 in bits 7..0.
// - High status byte: bit 7 zero, flags 21..15; all read-only.
// - Timebase FFD2, infrared transmit FFD4, receive FFD6, error FFD8.
// - SPI transmit FFDA, SPI receive FFDC, conversion done FFDE.
// - Keyboard FFE0, serial FFE2/FFE4/FFE6, two-wire FFE8, timer FFEA.
// - Vector high byte at even location, low byte next; bottom reserved.

`timescale 1ns/1ns

module ifvm_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ifvm_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral sources, bit n is source n
  input wire logic [ifvm_pkg::NSRC:1] src_req_i,
  // CPU vector fetch
  input wire logic vec_req_i,
  output logic vec_ready_o,
  output logic vec_ack_o,
  output logic vec_hit_o,
  output logic [4:0] vec_num_o,
  output logic [15:0] vec_hi_addr_o,
  output logic [15:0] vec_lo_addr_o,
  // Event interrupt
  output logic irq_o
);

  // ****************************************
  // Flag bank and arbiter
  // ****************************************
  ifvm_flag_if flags ();

  ifvm_flag_bank u_bank (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .src_req_i(src_req_i),
    .flags(flags.bank)
  );

  ifvm_vec_arb u_arb (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .flags(flags.arb)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [ifvm_pkg::EVT_W-1:0] evt_stat_r;
  logic [ifvm_pkg::EVT_W-1:0] evt_stat_nxt;
  logic [ifvm_pkg::EVT_W-1:0] evt_mask_r;
  logic [ifvm_pkg::NSRC:1] src_en_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [ifvm_pkg::EVT_W-1:0] evt_mask_nxt;
  logic [ifvm_pkg::NSRC:1] src_en_nxt;
  ifvm_pkg::ifvm_vf_t vf_state_r;
  ifvm_pkg::ifvm_vf_t vf_state_nxt;
  logic vec_hit_r;
  logic vec_hit_nxt;
  logic [4:0] vec_num_r;
  logic [4:0] vec_num_nxt;
  logic [15:0] vec_hi_r;
  logic [15:0] vec_hi_nxt;
  logic [15:0] vec_lo_r;
  logic [15:0] vec_lo_nxt;

  // ****************************************
  // Address decode helper
  // ****************************************

  // True when the bus address is the byte address of a register index
  function automatic logic ifvm_addr_is(
    logic [ifvm_pkg::APB_AW-1:0] addr,
    logic [15:0] idx
  );
    return addr == ifvm_pkg::ifvm_byte_addr(idx);
  endfunction

  // ****************************************
  // APB phase and register select
  // ****************************************
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic sel_low;
  logic sel_mid;
  logic sel_high;
  logic sel_stat;
  logic sel_mask;
  logic sel_en;
  logic sel_last;
  logic sel_any;
  logic sel_ro;

  // Bus phases; the slave never inserts wait states
  assign apb_setup = psel_i && !penable_i;
  assign apb_access = psel_i && penable_i;
  assign apb_wr = apb_access && pwrite_i;

  // One select per register word
  assign sel_low = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_PEND_LOW);
  assign sel_mid = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_PEND_MID);
  assign sel_high = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_PEND_HIGH);
  assign sel_stat = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_EVT_STAT);
  assign sel_mask = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_EVT_MASK);
  assign sel_en = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_SRC_EN);
  assign sel_last = ifvm_addr_is(paddr_i, ifvm_pkg::IDX_LAST_VEC);

  // Status words are read-only; a write to them is flagged, not taken
  assign sel_ro = sel_low | sel_mid | sel_high | sel_last;
  assign sel_any = sel_ro | sel_stat | sel_mask | sel_en;

  // Handshake answers in the first access cycle
  assign pready_o = apb_access;
  assign pslverr_o = apb_access && (!sel_any || (pwrite_i && sel_ro));

  // ****************************************
  // Status byte views
  // ****************************************
  logic [7:0] stat_low;
  logic [7:0] stat_mid;
  logic [7:0] stat_high;
  logic [31:0] rd_mux;

  // Flags 6..1 sit in bits 7..2, the two low bits read zero
  assign stat_low = {flags.pend[6:1], 2'b00};
  // Flags 14..7 fill the whole byte
  assign stat_mid = flags.pend[14:7];
  // Top bit reads zero, flags 21..15 below it
  assign stat_high = {1'b0, flags.pend[21:15]};

  // Read selection; selects are exclusive so an OR of masked words is safe
  assign rd_mux = ({32{sel_low}} & {24'h000000, stat_low})
                | ({32{sel_mid}} & {24'h000000, stat_mid})
                | ({32{sel_high}} & {24'h000000, stat_high})
                | ({32{sel_stat}} & {29'h0000000, evt_stat_r})
                | ({32{sel_mask}} & {29'h0000000, evt_mask_r})
                | ({32{sel_en}} & {11'h000, src_en_r})
                | ({32{sel_last}} & {16'h0000, vec_hi_r});

  // Read data is captured in the setup cycle and stands through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (apb_setup && !pwrite_i) begin
      prdata_nxt = rd_mux;
    end
  end

  assign prdata_o = prdata_r;

  // ****************************************
  // Writable controls
  // ****************************************

  // Mask and source enable take the write in the access cycle only
  assign evt_mask_nxt = (apb_wr && sel_mask) ?
                        pwdata_i[ifvm_pkg::EVT_W-1:0] : evt_mask_r;
  assign src_en_nxt = (apb_wr && sel_en) ?
                      pwdata_i[ifvm_pkg::NSRC-1:0] : src_en_r;

  // Disabled sources still show in the status bytes but never win
  assign flags.en = src_en_r;

  // ****************************************
  // Events and interrupt
  // ****************************************
  logic fetch_go;
  logic [ifvm_pkg::EVT_W-1:0] evt_set;
  logic [ifvm_pkg::EVT_W-1:0] evt_clr;

  // A fetch starts when the core asks while the sequencer is idle
  assign fetch_go = vec_req_i && (vf_state_r == ifvm_pkg::VF_IDLE);

  // Event sources: a flag newly raised, a fetch with or without a winner
  assign evt_set[ifvm_pkg::EVT_NEW] = |flags.rise;
  assign evt_set[ifvm_pkg::EVT_FETCH] = fetch_go && flags.win_vld;
  assign evt_set[ifvm_pkg::EVT_EMPTY] = fetch_go && !flags.win_vld;

  // Write one to clear; a set in the same cycle wins so no event is lost
  assign evt_clr = (apb_wr && sel_stat) ?
                   pwdata_i[ifvm_pkg::EVT_W-1:0] :
                   {ifvm_pkg::EVT_W{1'b0}};
  assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;

  // Level interrupt while any unmasked event bit stands
  assign irq_o = |(evt_stat_r & evt_mask_r);

  // ****************************************
  // Vector location
  // ****************************************
  logic [15:0] vec_loc;

  // Winner's even high-byte location; no winner points at the reserved pair
  assign vec_loc = flags.win_vld ?
                   ifvm_pkg::ifvm_vec_loc(flags.win_num) :
                   ifvm_pkg::VEC_BASE;

  // Captured at fetch start so a flag change mid-fetch cannot tear the pair
  assign vec_hit_nxt = fetch_go ? flags.win_vld : vec_hit_r;
  assign vec_num_nxt = fetch_go ? flags.win_num : vec_num_r;
  assign vec_hi_nxt = fetch_go ? vec_loc : vec_hi_r;
  // Low byte sits at the next odd location
  assign vec_lo_nxt = fetch_go ? (vec_loc + 16'h0001) : vec_lo_r;

  // ****************************************
  // Fetch sequencer
  // ****************************************

  // Idle until asked, then one acknowledge cycle with the pair standing
  always_comb begin
    vf_state_nxt = vf_state_r;
    unique case (vf_state_r)
      ifvm_pkg::VF_IDLE: begin
        if (vec_req_i) begin
          vf_state_nxt = ifvm_pkg::VF_ACK;
        end
      end
      ifvm_pkg::VF_ACK: begin
        vf_state_nxt = ifvm_pkg::VF_IDLE;
      end
      default: begin
        vf_state_nxt = ifvm_pkg::VF_IDLE;
      end
    endcase
  end

  assign vec_ready_o = (vf_state_r == ifvm_pkg::VF_IDLE);
  assign vec_ack_o = (vf_state_r == ifvm_pkg::VF_ACK);
  assign vec_hit_o = vec_hit_r;
  assign vec_num_o = vec_num_r;
  assign vec_hi_addr_o = vec_hi_r;
  assign vec_lo_addr_o = vec_lo_r;

  // ****************************************
  // State flops
  // ****************************************

  // Bus side registers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_stat_r <= ifvm_pkg::EVT_STAT_RST;
      evt_mask_r <= ifvm_pkg::EVT_MASK_RST;
      src_en_r <= ifvm_pkg::SRC_EN_RST;
      prdata_r <= 32'h00000000;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      src_en_r <= src_en_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Fetch side registers; reset points at the reserved pair
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vf_state_r <= ifvm_pkg::VF_IDLE;
      vec_hit_r <= 1'b0;
      vec_num_r <= 5'h00;
      vec_hi_r <= ifvm_pkg::VEC_BASE;
      vec_lo_r <= ifvm_pkg::VEC_BASE + 16'h0001;
    end else begin
      vf_state_r <= vf_state_nxt;
      vec_hit_r <= vec_hit_nxt;
      vec_num_r <= vec_num_nxt;
      vec_hi_r <= vec_hi_nxt;
      vec_lo_r <= vec_lo_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  // A fetch is asked for while the sequencer is ready
  sequence s_fetch_start;
    vec_req_i && vec_ready_o;
  endsequence

  // The acknowledge cycle that follows
  sequence s_fetch_ack;
    vec_ack_o && !vec_ready_o;
  endsequence

  chk_fetch_ack_next: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_fetch_start |=> s_fetch_ack)
    else $error("fetch not acknowledged in the next cycle");

  chk_vec_pair_odd: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    vec_ack_o |-> !vec_hi_addr_o[0] &&
      (vec_lo_addr_o == vec_hi_addr_o + 16'h0001))
    else $error("vector pair not even then odd");

  chk_vec_above_rsvd: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    vec_ack_o && vec_hit_o |-> vec_hi_addr_o > ifvm_pkg::VEC_BASE)
    else $error("pending source fetched the reserved pair");

  chk_low_byte_zero: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    apb_access && !pwrite_i && sel_low |-> prdata_o[1:0] == 2'b00)
    else $error("low status byte shows set low bits");

  chk_high_bit_zero: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    apb_access && !pwrite_i && sel_high |-> prdata_o[7] == 1'b0)
    else $error("high status byte shows set top bit");

endmodule

// >>> sim/ifvm_cpu_model.sv
// Purpose: CPU core model that fetches interrupt vectors.
// Assumes: Request is held until acknowledge is seen at a rising edge.
// Notes:   An idle gap before a fetch models a slow core.
`timescale 1ns/1ns
module ifvm_cpu_model (
  // Clock
  input wire logic ref_clk_i,
  // Fetch handshake
  input wire logic vec_ack_i,
  input wire logic [15:0] vec_hi_addr_i,
  input wire logic [15:0] vec_lo_addr_i,
  output logic vec_req_o
);
  initial vec_req_o = 1'b0;
  // Bounded wait, so a dead acknowledge cannot hang the core
  task automatic fetch(input int gap, output logic [15:0] hi,
                       output logic [15:0] lo);
    int n;
    n = 0;
    repeat (gap) @(posedge ref_clk_i);
    vec_req_o <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (vec_ack_i !== 1'b1 && n < 50);
    hi = vec_hi_addr_i;
    lo = vec_lo_addr_i;
    vec_req_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask
endmodule

// >>> sim/testbench.sv
// Purpose: Self-checking bench for status bytes and vector fetch.
// Assumes: Register byte address is four times the index.
// Notes:   In the fetch tests, sources are held until their vector is fetched.
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, ack, req;
  logic slverr, berr, hit, irq, vrdy;
  logic [4:0] vnum;
  logic [15:0] vhi, vlo;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [21:1] src = '0;
  logic [15:0] hi, lo, exp;
  int err_total = 0, comparisons = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  ifvm_top ifvm_top_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(slverr), .src_req_i(src),
    .vec_req_i(req), .vec_ready_o(vrdy), .vec_ack_o(ack),
    .vec_hit_o(hit), .vec_num_o(vnum),
    .vec_hi_addr_o(vhi), .vec_lo_addr_o(vlo), .irq_o(irq));
  ifvm_cpu_model ifvm_cpu_model_i (.ref_clk_i(ref_clk_i),
    .vec_ack_i(ack), .vec_hi_addr_i(vhi), .vec_lo_addr_i(vlo),
    .vec_req_o(req));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  // One APB transfer; setup cycle, then access until ready
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    berr = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int i = 4; i < 7; i++) begin
      apb(1'b0, 16'hFE00 + 16'(i), 32'h0);
      chk(rd, 32'h0);
    end
    src <= '1;
    repeat (3) @(posedge ref_clk_i);
    apb(1'b0, 16'hFE04, 32'h0);
    chk(rd, 32'hFC);
    apb(1'b0, 16'hFE05, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, 16'hFE06, 32'h0);
    chk(berr, 32'h1);
    apb(1'b0, 16'hFE06, 32'h0);
    chk(rd, 32'h7F);
    src <= '0;
    // Sources 9 to 21 alone, core idle gap cycling through 0, 1 and 2 cycles
    for (int n = 9; n <= 21; n++) begin
      src[n] <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      ifvm_cpu_model_i.fetch(n % 3, hi, lo);
      exp = 16'hFFD2 + 16'(2 * (21 - n));
      chk(hi, exp);
      chk(lo, exp + 16'h1);
      src <= '0;
      repeat (3) @(posedge ref_clk_i);
    end
    // Several pending: highest vector wins
    src <= 21'h104100;
    repeat (3) @(posedge ref_clk_i);
    ifvm_cpu_model_i.fetch(0, hi, lo);
    chk(hi, 16'hFFEA);
    src[9] <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    ifvm_cpu_model_i.fetch(0, hi, lo);
    chk(hi, 16'hFFDE);
    chk(vnum, 32'hF);
    // All sources disabled: the fetch lands on the reserved pair
    apb(1'b1, 16'hFE12, 32'h0);
    ifvm_cpu_model_i.fetch(0, hi, lo);
    chk(hi, 16'hFFD0);
    chk(hit, 32'h0);
    chk(vrdy, 32'h1);
    apb(1'b1, 16'hFE12, 32'h1FFFFF);
    apb(1'b0, 16'hFE13, 32'h0);
    chk(rd, 32'hFFD0);
    // Events: new flag, fetch with and without a winner
    apb(1'b0, 16'hFE10, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, 16'hFE11, 32'h4);
    chk(irq, 32'h1);
    apb(1'b1, 16'hFE10, 32'h7);
    chk(irq, 32'h0);
    apb(1'b0, 16'hFE10, 32'h0);
    chk(rd, 32'h0);
    final_report();
  end
  // Watchdog well past the expected run length
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
